/* File: hdl/pdpm_pkg.sv */
// package: register map, field layout, reset values and carriers for the port mux
package pdpm_pkg;
    localparam int PDPM_AW = 4;
    // register offsets
    localparam logic [3:0] PDPM_OFS_A_DATA = 4'h0;
    localparam logic [3:0] PDPM_OFS_A_DIR = 4'h1;
    localparam logic [3:0] PDPM_OFS_B_DATA = 4'h2;
    localparam logic [3:0] PDPM_OFS_B_DIR = 4'h3;
    localparam logic [3:0] PDPM_OFS_C_DATA = 4'h4;
    localparam logic [3:0] PDPM_OFS_C_DIR = 4'h5;
    localparam logic [3:0] PDPM_OFS_A_SEL_LO = 4'h6;
    localparam logic [3:0] PDPM_OFS_A_SEL_HI = 4'h7;
    localparam logic [3:0] PDPM_OFS_B_SEL_HI = 4'h8;
    localparam logic [3:0] PDPM_OFS_C_SEL_LO = 4'h9;
    localparam logic [3:0] PDPM_OFS_C_SEL_HI = 4'hA;
    // reset values
    localparam logic [7:0] PDPM_RST_DIR = 8'hFF;
    localparam logic [7:0] PDPM_RST_DATA = 8'hFF;
    localparam logic [7:0] PDPM_RST_SEL = 8'h00;
    // implemented bits
    localparam logic [7:0] PDPM_MASK_A_SEL_LO = 8'hCC;
    localparam logic [7:0] PDPM_MASK_A_SEL_HI = 8'h03;
    localparam logic [7:0] PDPM_MASK_B_PORT = 8'hFE;
    // field positions (low bit of each two-bit selector)
    localparam int PDPM_POS_A3 = 6;
    localparam int PDPM_POS_A1 = 2;
    localparam int PDPM_POS_A4 = 0;
    localparam int PDPM_POS_B7 = 6;
    localparam int PDPM_POS_B6 = 4;
    localparam int PDPM_POS_B5 = 2;
    localparam int PDPM_POS_B4 = 0;
    // selector codes
    localparam logic [1:0] PDPM_CODE_ALT2 = 2'h2;
    localparam logic [1:0] PDPM_CODE_ALT3 = 2'h3;

    typedef struct packed {
        logic [PDPM_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pdpm_bus_req_t;

    typedef struct packed {
        logic electrolum_common_out;
        logic electrolum_pulse_out;
        logic timer_output;
        logic timer_output_inverted;
        logic lcd_segment_eight;
        logic lcd_segment_nine;
        logic lcd_segment_ten;
        logic lcd_segment_eleven;
    } pdpm_periph_t;

    typedef struct packed {
        logic [7:0] a_out;
        logic [7:0] a_oe;
        logic [7:0] b_out;
        logic [7:0] b_oe;
        logic [7:0] c_out;
        logic [7:0] c_oe;
    } pdpm_pins_t;
endpackage : pdpm_pkg

/* File: hdl/pdpm_port_mux.sv */
// port direction registers, data latches and pin-shared function routing
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - direction bit one makes pin an input
// - direction bit zero drives latch push-pull
// - input pin reads present synchronised level
// - output pin reads its output latch
// - one direction register per port, bit per pin
// - pin a3 selector: 10 common, 11 timer
// - first port a selector gaps read zero
// - pin a1 selector code 11 pulse output
// - second port a selector upper bits zero
// - pin a4 selector code 11 inverted timer
// - pin b7 selector code 11 segment eleven
// - pin b6 selector code 11 segment ten
// - pin b5 selector code 11 segment nine
// - pin b4 selector code 11 segment eight
module pdpm_port_mux (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire pdpm_pkg::pdpm_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // peripheral signals
    input wire pdpm_pkg::pdpm_periph_t periph,
    // pads
    input wire logic [7:0] pin_a_in,
    input wire logic [7:0] pin_b_in,
    input wire logic [7:0] pin_c_in,
    output pdpm_pkg::pdpm_pins_t pins,
    // port c selectors for the segment driver outside
    output logic [7:0] port_c_sel_lo,
    output logic [7:0] port_c_sel_hi
);
    import pdpm_pkg::*;

    typedef struct packed {
        logic [7:0] a_lat;
        logic [7:0] b_lat;
        logic [7:0] c_lat;
        logic [7:0] a_dir;
        logic [7:0] b_dir;
        logic [7:0] c_dir;
        logic [7:0] a_sel_lo;
        logic [7:0] a_sel_hi;
        logic [7:0] b_sel_hi;
        logic [7:0] c_sel_lo;
        logic [7:0] c_sel_hi;
        logic [2:0][7:0] s1;
        logic [2:0][7:0] s2;
        logic [2:0][7:0] s3;
        logic [2:0][7:0] lvl;
        logic [7:0] rdata;
        pdpm_pins_t pins;
    } pdpm_state_t;

    pdpm_state_t state_ff;
    pdpm_state_t nxt_state;

    // pick a two-bit field
    function automatic logic [1:0] pdpm_field(input logic [7:0] r,
                                              input int pos);
        pdpm_field = r[pos+:2];
    endfunction

    // port read: level when input, latch when output
    function automatic logic [7:0] pdpm_port_rd(input logic [7:0] dir,
                                                input logic [7:0] lvl,
                                                input logic [7:0] lat);
        pdpm_port_rd = (dir & lvl) | (~dir & lat);
    endfunction

    logic [7:0] a_drv;
    logic [7:0] b_drv;
    logic [7:0] a_force;
    logic [7:0] b_force;

    always_comb begin
        a_drv = state_ff.a_lat;
        b_drv = state_ff.b_lat;
        a_force = 8'h00;
        b_force = 8'h00;
        unique case (pdpm_field(state_ff.a_sel_lo, PDPM_POS_A3))
            PDPM_CODE_ALT2: begin
                a_drv[3] = periph.electrolum_common_out;
                a_force[3] = 1'b1;
            end
            PDPM_CODE_ALT3: begin
                a_drv[3] = periph.timer_output;
                a_force[3] = 1'b1;
            end
            default: begin
            end
        endcase
        if (pdpm_field(state_ff.a_sel_lo, PDPM_POS_A1) == PDPM_CODE_ALT3) begin
            a_drv[1] = periph.electrolum_pulse_out;
            a_force[1] = 1'b1;
        end
        if (pdpm_field(state_ff.a_sel_hi, PDPM_POS_A4) == PDPM_CODE_ALT3) begin
            a_drv[4] = periph.timer_output_inverted;
            a_force[4] = 1'b1;
        end
        if (pdpm_field(state_ff.b_sel_hi, PDPM_POS_B7) == PDPM_CODE_ALT3) begin
            b_drv[7] = periph.lcd_segment_eleven;
            b_force[7] = 1'b1;
        end
        if (pdpm_field(state_ff.b_sel_hi, PDPM_POS_B6) == PDPM_CODE_ALT3) begin
            b_drv[6] = periph.lcd_segment_ten;
            b_force[6] = 1'b1;
        end
        if (pdpm_field(state_ff.b_sel_hi, PDPM_POS_B5) == PDPM_CODE_ALT3) begin
            b_drv[5] = periph.lcd_segment_nine;
            b_force[5] = 1'b1;
        end
        if (pdpm_field(state_ff.b_sel_hi, PDPM_POS_B4) == PDPM_CODE_ALT3) begin
            b_drv[4] = periph.lcd_segment_eight;
            b_force[4] = 1'b1;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        // pad synchroniser: three stages, change taken when 2 and 3 agree
        nxt_state.s1 = {pin_c_in, pin_b_in, pin_a_in};
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 8; i++) begin
                if (state_ff.s2[p][i] == state_ff.s3[p][i]) begin
                    nxt_state.lvl[p][i] = state_ff.s3[p][i];
                end
            end
        end
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                PDPM_OFS_A_DATA: nxt_state.a_lat = bus_req.wdata;
                PDPM_OFS_A_DIR: nxt_state.a_dir = bus_req.wdata;
                PDPM_OFS_B_DATA:
                    nxt_state.b_lat = bus_req.wdata & PDPM_MASK_B_PORT;
                PDPM_OFS_B_DIR:
                    nxt_state.b_dir = bus_req.wdata | ~PDPM_MASK_B_PORT;
                PDPM_OFS_C_DATA: nxt_state.c_lat = bus_req.wdata;
                PDPM_OFS_C_DIR: nxt_state.c_dir = bus_req.wdata;
                PDPM_OFS_A_SEL_LO:
                    nxt_state.a_sel_lo = bus_req.wdata & PDPM_MASK_A_SEL_LO;
                PDPM_OFS_A_SEL_HI:
                    nxt_state.a_sel_hi = bus_req.wdata & PDPM_MASK_A_SEL_HI;
                PDPM_OFS_B_SEL_HI: nxt_state.b_sel_hi = bus_req.wdata;
                PDPM_OFS_C_SEL_LO: nxt_state.c_sel_lo = bus_req.wdata;
                PDPM_OFS_C_SEL_HI: nxt_state.c_sel_hi = bus_req.wdata;
                default: begin
                end
            endcase
        end
        nxt_state.rdata = 8'h00;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                PDPM_OFS_A_DATA: nxt_state.rdata = pdpm_port_rd(state_ff.a_dir,
                    state_ff.lvl[0], state_ff.a_lat);
                PDPM_OFS_A_DIR: nxt_state.rdata = state_ff.a_dir;
                PDPM_OFS_B_DATA: nxt_state.rdata = pdpm_port_rd(state_ff.b_dir,
                    state_ff.lvl[1], state_ff.b_lat) & PDPM_MASK_B_PORT;
                PDPM_OFS_B_DIR:
                    nxt_state.rdata = state_ff.b_dir & PDPM_MASK_B_PORT;
                PDPM_OFS_C_DATA: nxt_state.rdata = pdpm_port_rd(state_ff.c_dir,
                    state_ff.lvl[2], state_ff.c_lat);
                PDPM_OFS_C_DIR: nxt_state.rdata = state_ff.c_dir;
                PDPM_OFS_A_SEL_LO: nxt_state.rdata = state_ff.a_sel_lo;
                PDPM_OFS_A_SEL_HI: nxt_state.rdata = state_ff.a_sel_hi;
                PDPM_OFS_B_SEL_HI: nxt_state.rdata = state_ff.b_sel_hi;
                PDPM_OFS_C_SEL_LO: nxt_state.rdata = state_ff.c_sel_lo;
                PDPM_OFS_C_SEL_HI: nxt_state.rdata = state_ff.c_sel_hi;
                default: nxt_state.rdata = 8'h00;
            endcase
        end
        // pad drive, registered
        nxt_state.pins.a_out = a_drv;
        nxt_state.pins.a_oe = ~state_ff.a_dir | a_force;
        nxt_state.pins.b_out = b_drv & PDPM_MASK_B_PORT;
        nxt_state.pins.b_oe = (~state_ff.b_dir | b_force) & PDPM_MASK_B_PORT;
        nxt_state.pins.c_out = state_ff.c_lat;
        nxt_state.pins.c_oe = ~state_ff.c_dir;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_ff <= '0;
            state_ff.a_lat <= PDPM_RST_DATA;
            state_ff.b_lat <= PDPM_RST_DATA & PDPM_MASK_B_PORT;
            state_ff.c_lat <= PDPM_RST_DATA;
            state_ff.a_dir <= PDPM_RST_DIR;
            state_ff.b_dir <= PDPM_RST_DIR;
            state_ff.c_dir <= PDPM_RST_DIR;
            state_ff.a_sel_lo <= PDPM_RST_SEL;
            state_ff.a_sel_hi <= PDPM_RST_SEL;
            state_ff.b_sel_hi <= PDPM_RST_SEL;
            state_ff.c_sel_lo <= PDPM_RST_SEL;
            state_ff.c_sel_hi <= PDPM_RST_SEL;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus_rdata = state_ff.rdata;
    assign pins = state_ff.pins;
    assign port_c_sel_lo = state_ff.c_sel_lo;
    assign port_c_sel_hi = state_ff.c_sel_hi;

    ////////////////////////////////////////////////////////////////////////
    // checks

    // direction and drive
    chk_input_no_drive: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.c_dir[0] && $past(state_ff.c_dir[0]))
        |-> !pins.c_oe[0])
        else $error("input pin is driven");
    chk_output_drives_latch: assert property (
        @(posedge clk) disable iff (!rstn)
        (!state_ff.c_dir[2] && $stable(state_ff.c_lat[2]))
        |=> (pins.c_oe[2] && pins.c_out[2] == $past(state_ff.c_lat[2])))
        else $error("output pin not driven from latch");
    chk_b_dir_bit0: assert property (
        @(posedge clk) disable iff (!rstn)
        !pins.b_oe[0])
        else $error("missing port b pin driven");

    // register reads
    chk_read_input_level: assert property (
        @(posedge clk) disable iff (!rstn)
        (bus_req.rd && bus_req.addr == PDPM_OFS_A_DATA && state_ff.a_dir[5])
        |=> bus_rdata[5] == $past(state_ff.lvl[0][5]))
        else $error("input read not pin level");
    chk_read_output_latch: assert property (
        @(posedge clk) disable iff (!rstn)
        (bus_req.rd && bus_req.addr == PDPM_OFS_A_DATA && !state_ff.a_dir[5])
        |=> bus_rdata[5] == $past(state_ff.a_lat[5]))
        else $error("output read not latch");
    chk_sync_agree: assert property (
        @(posedge clk) disable iff (!rstn)
        ((state_ff.lvl ^ $past(state_ff.lvl))
        & ($past(state_ff.s2) ^ $past(state_ff.s3))) == 24'h000000)
        else $error("pad level taken before two stages agree");
    chk_b_read_bit0: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(bus_req.rd && (bus_req.addr == PDPM_OFS_B_DATA
        || bus_req.addr == PDPM_OFS_B_DIR)) |-> !bus_rdata[0])
        else $error("missing port b bit reads one");
    chk_sel_lo_read: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(bus_req.rd && bus_req.addr == PDPM_OFS_A_SEL_LO)
        |-> (bus_rdata & ~PDPM_MASK_A_SEL_LO) == 8'h00)
        else $error("first selector gaps not zero");
    chk_a_sel_lo_gaps: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.a_sel_lo & ~PDPM_MASK_A_SEL_LO) == 8'h00)
        else $error("unimplemented selector bits set");
    chk_a_sel_hi_gaps: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(bus_req.rd && bus_req.addr == PDPM_OFS_A_SEL_HI)
        |-> bus_rdata[7:2] == 6'h00)
        else $error("upper selector bits not zero");

    // selector routing
    chk_a3_timer_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.a_sel_lo[7:6] == PDPM_CODE_ALT3)
        |=> (pins.a_oe[3] && pins.a_out[3] == $past(periph.timer_output)))
        else $error("pin a3 not routed to timer");
    chk_a3_common_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.a_sel_lo[7:6] == PDPM_CODE_ALT2)
        |=> (pins.a_oe[3]
        && pins.a_out[3] == $past(periph.electrolum_common_out)))
        else $error("pin a3 not routed to common");
    chk_a3_no_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (!state_ff.a_sel_lo[7] && state_ff.a_dir[3]) |=> !pins.a_oe[3])
        else $error("pin a3 driven while general input");
    chk_a1_pulse_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.a_sel_lo[3:2] == PDPM_CODE_ALT3)
        |=> pins.a_out[1] == $past(periph.electrolum_pulse_out))
        else $error("pin a1 not routed to pulse");
    chk_a1_no_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.a_sel_lo[3:2] != PDPM_CODE_ALT3 && state_ff.a_dir[1])
        |=> !pins.a_oe[1])
        else $error("pin a1 driven while general input");
    chk_a4_inv_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.a_sel_hi[1:0] == PDPM_CODE_ALT3)
        |=> pins.a_out[4] == $past(periph.timer_output_inverted))
        else $error("pin a4 not routed to inverted timer");
    chk_a4_no_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.a_sel_hi[1:0] != PDPM_CODE_ALT3 && state_ff.a_dir[4])
        |=> !pins.a_oe[4])
        else $error("pin a4 driven while general input");
    chk_b7_seg_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.b_sel_hi[7:6] == PDPM_CODE_ALT3)
        |=> pins.b_out[7] == $past(periph.lcd_segment_eleven))
        else $error("pin b7 not routed to segment");
    chk_b7_no_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.b_sel_hi[7:6] != PDPM_CODE_ALT3 && state_ff.b_dir[7])
        |=> !pins.b_oe[7])
        else $error("pin b7 driven while general input");
    chk_b6_seg_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.b_sel_hi[5:4] == PDPM_CODE_ALT3)
        |=> pins.b_out[6] == $past(periph.lcd_segment_ten))
        else $error("pin b6 not routed to segment");
    chk_b5_seg_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.b_sel_hi[3:2] == PDPM_CODE_ALT3)
        |=> pins.b_out[5] == $past(periph.lcd_segment_nine))
        else $error("pin b5 not routed to segment");
    chk_b4_seg_route: assert property (
        @(posedge clk) disable iff (!rstn)
        (state_ff.b_sel_hi[1:0] == PDPM_CODE_ALT3)
        |=> pins.b_out[4] == $past(periph.lcd_segment_eight))
        else $error("pin b4 not routed to segment");

    cov_a3_common: cover property (@(posedge clk) disable iff (!rstn)
        state_ff.a_sel_lo[7:6] == PDPM_CODE_ALT2);
    cov_output_read: cover property (@(posedge clk) disable iff (!rstn)
        bus_req.rd && bus_req.addr == PDPM_OFS_B_DATA && !state_ff.b_dir[3]);
    cov_input_read: cover property (@(posedge clk) disable iff (!rstn)
        bus_req.rd && bus_req.addr == PDPM_OFS_C_DATA && state_ff.c_dir[1]);
    cov_seg_route: cover property (@(posedge clk) disable iff (!rstn)
        state_ff.b_sel_hi == 8'hFF);
    cov_a4_inverted: cover property (@(posedge clk) disable iff (!rstn)
        state_ff.a_sel_hi[1:0] == PDPM_CODE_ALT3 && pins.a_out[4]);

endmodule // pdpm_port_mux

`default_nettype wire

/* File: tb/pdpm_pad_model.sv */
// pad model: resolves each pad level from the design's drive and outside sources
`timescale 1ns/10ps
`default_nettype none

module pdpm_pad_model (
    // design pad drive
    input wire pdpm_pkg::pdpm_pins_t pins,
    // outside sources
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_b,
    input wire logic [7:0] ext_c,
    input wire logic short_a,
    // levels seen by the design
    output logic [7:0] pin_a_in,
    output logic [7:0] pin_b_in,
    output logic [7:0] pin_c_in
);
    import pdpm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // a driven pad shows the drive, an undriven one the outside source
    // a hard short to the outside source wins over the pad driver
    assign pin_a_in = short_a ? ext_a :
        ((pins.a_oe & pins.a_out) | (~pins.a_oe & ext_a));
    assign pin_b_in = (pins.b_oe & pins.b_out) | (~pins.b_oe & ext_b);
    assign pin_c_in = (pins.c_oe & pins.c_out) | (~pins.c_oe & ext_c);
endmodule // pdpm_pad_model

`default_nettype wire

/* File: tb/testbench.sv */
// testbench: register access, direction, readback and pin routing checks
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import pdpm_pkg::*;

    logic clk;
    logic rstn;
    pdpm_bus_req_t bus_req;
    logic [7:0] bus_rdata;
    pdpm_periph_t periph;
    logic [7:0] pin_a_in;
    logic [7:0] pin_b_in;
    logic [7:0] pin_c_in;
    pdpm_pins_t pins;
    logic [7:0] port_c_sel_lo;
    logic [7:0] port_c_sel_hi;
    logic [7:0] ext_a;
    logic [7:0] ext_b;
    logic [7:0] ext_c;
    logic short_a;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int src;
    // per selector field: register, position, port, pin, code 11 source bit
    logic [3:0] f_ofs [7] = '{PDPM_OFS_A_SEL_LO, PDPM_OFS_A_SEL_LO,
        PDPM_OFS_A_SEL_HI, PDPM_OFS_B_SEL_HI, PDPM_OFS_B_SEL_HI,
        PDPM_OFS_B_SEL_HI, PDPM_OFS_B_SEL_HI};
    int f_pos [7] = '{6, 2, 0, 6, 4, 2, 0};
    int f_port [7] = '{0, 0, 0, 1, 1, 1, 1};
    int f_pin [7] = '{3, 1, 4, 7, 6, 5, 4};
    int f_src3 [7] = '{5, 6, 4, 0, 1, 2, 3};

    pdpm_port_mux dut_u (
        .clk(clk),
        .rstn(rstn),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .periph(periph),
        .pin_a_in(pin_a_in),
        .pin_b_in(pin_b_in),
        .pin_c_in(pin_c_in),
        .pins(pins),
        .port_c_sel_lo(port_c_sel_lo),
        .port_c_sel_hi(port_c_sel_hi)
    );

    pdpm_pad_model pad_u (
        .pins(pins),
        .ext_a(ext_a),
        .ext_b(ext_b),
        .ext_c(ext_c),
        .short_a(short_a),
        .pin_a_in(pin_a_in),
        .pin_b_in(pin_b_in),
        .pin_c_in(pin_c_in)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("mismatches %0d comparisons %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #10;
        check(bus_rdata, exp);
    endtask

    // enable and drive of one pad as {oe, out}
    function automatic logic [7:0] pad(input int p, input int b);
        if (p == 0) begin
            return {6'h00, pins.a_oe[b], pins.a_out[b]};
        end
        return {6'h00, pins.b_oe[b], pins.b_out[b]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            $display("BAD %0t: run did not finish in time", $time);
            results();
        end
    end

    initial begin
        rstn = 1'b0;
        bus_req = '0;
        periph = '0;
        ext_a = 8'hA5;
        ext_b = 8'h3C;
        ext_c = 8'h96;
        short_a = 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        #10;
        // reset state, all pins inputs
        check(pins.a_oe | pins.b_oe | pins.c_oe, 8'h00);
        rd_chk(PDPM_OFS_A_DIR, 8'hFF);
        rd_chk(PDPM_OFS_B_DIR, 8'hFE);
        rd_chk(PDPM_OFS_C_DIR, 8'hFF);
        rd_chk(PDPM_OFS_A_DATA, 8'hA5);
        rd_chk(PDPM_OFS_B_DATA, 8'h3C);
        rd_chk(PDPM_OFS_C_DATA, 8'h96);
        rd_chk(PDPM_OFS_A_SEL_LO, 8'h00);
        rd_chk(PDPM_OFS_A_SEL_HI, 8'h00);
        rd_chk(PDPM_OFS_B_SEL_HI, 8'h00);
        rd_chk(4'hF, 8'h00);
        // mixed directions with all port a pads shorted outside
        wr(PDPM_OFS_A_DATA, 8'h3C);
        wr(PDPM_OFS_A_DIR, 8'h0F);
        wr(PDPM_OFS_C_DATA, 8'h5A);
        wr(PDPM_OFS_C_DIR, 8'h00);
        wr(PDPM_OFS_B_DIR, 8'h00);
        repeat (3) @(posedge clk);
        #10;
        check(pins.a_oe, 8'hF0);
        check(pins.a_out & 8'hF0, 8'h30);
        check(pins.c_oe, 8'hFF);
        check(pins.c_out, 8'h5A);
        check(pins.b_oe, 8'hFE);
        @(posedge clk);
        short_a <= 1'b1;
        repeat (6) @(posedge clk);
        rd_chk(PDPM_OFS_A_DATA, 8'h35);
        wr(PDPM_OFS_A_DIR, 8'hFF);
        wr(PDPM_OFS_B_DIR, 8'hFF);
        rd_chk(PDPM_OFS_A_DATA, 8'hA5);
        // unimplemented selector bits and port c selectors
        wr(PDPM_OFS_A_SEL_LO, 8'hFF);
        rd_chk(PDPM_OFS_A_SEL_LO, 8'hCC);
        wr(PDPM_OFS_A_SEL_HI, 8'hFF);
        rd_chk(PDPM_OFS_A_SEL_HI, 8'h03);
        wr(PDPM_OFS_B_SEL_HI, 8'hFF);
        rd_chk(PDPM_OFS_B_SEL_HI, 8'hFF);
        wr(PDPM_OFS_C_SEL_LO, 8'h5A);
        wr(PDPM_OFS_C_SEL_HI, 8'hA5);
        rd_chk(PDPM_OFS_C_SEL_LO, 8'h5A);
        rd_chk(PDPM_OFS_C_SEL_HI, 8'hA5);
        check(port_c_sel_lo, 8'h5A);
        check(port_c_sel_hi, 8'hA5);
        wr(PDPM_OFS_A_SEL_LO, 8'h00);
        wr(PDPM_OFS_A_SEL_HI, 8'h00);
        wr(PDPM_OFS_B_SEL_HI, 8'h00);
        // every code of every selector field, routed and not routed
        for (int i = 0; i < 7; i++) begin
            for (int c = 0; c < 4; c++) begin
                src = (c == 3) ? f_src3[i] : (i == 0 && c == 2) ? 7 : -1;
                @(posedge clk);
                periph <= '0;
                wr(f_ofs[i], 8'(c << f_pos[i]));
                rd_chk(f_ofs[i], 8'(c << f_pos[i]));
                @(posedge clk);
                #10;
                check(pad(f_port[i], f_pin[i]) & ((src < 0) ? 8'h02 : 8'h03),
                    (src < 0) ? 8'h00 : 8'h02);
                if (src >= 0) begin
                    @(posedge clk);
                    periph <= pdpm_periph_t'(8'(1 << src));
                    repeat (2) @(posedge clk);
                    #10;
                    check(pad(f_port[i], f_pin[i]), 8'h03);
                end
            end
            @(posedge clk);
            periph <= '0;
            wr(f_ofs[i], 8'h00);
        end
        results();
    end
endmodule // testbench

`default_nettype wire
